/* File: src/stc_pkg.sv */
package stc_pkg;

    // ************************************************
    // clock and timing
    // ************************************************
    localparam int unsigned CLK_HZ      = 100_000_000; // system clock rate
    localparam int unsigned SUB_DIV_DEF = 3052;        // sub clock divide, plain default
    localparam int unsigned SUB_W       = 12;          // sub divider width

    // ************************************************
    // register byte addresses
    // ************************************************
    localparam logic [7:0] ADDR_CTRL_FIRST  = 8'h00; // timer_control_first
    localparam logic [7:0] ADDR_CTRL_SECOND = 8'h04; // timer_control_second
    localparam logic [7:0] ADDR_CNT_LOW     = 8'h08; // counter_low_byte
    localparam logic [7:0] ADDR_CNT_HIGH    = 8'h0c; // counter_high_byte
    localparam logic [7:0] ADDR_CMPA_LOW    = 8'h10; // compare_a_low_byte
    localparam logic [7:0] ADDR_CMPA_HIGH   = 8'h14; // compare_a_high_byte
    localparam logic [7:0] ADDR_CMPP        = 8'h18; // compare_p_upper_value
    localparam logic [7:0] ADDR_FLAGS       = 8'h1c; // event flags, write one to clear

    // ************************************************
    // field positions
    // ************************************************
    localparam int unsigned CTRL0_LSB  = 3; // first control bits 7..3 stored
    localparam int unsigned FLAG_A_BIT = 0; // compare_a_flag position
    localparam int unsigned FLAG_P_BIT = 1; // compare_p_flag position

    // ************************************************
    // encodings
    // ************************************************
    typedef enum logic [1:0] {
        MODE_COMPARE = 2'h0, // compare match output
        MODE_UNDEF   = 2'h1, // undefined
        MODE_PWM     = 2'h2, // pwm or single pulse
        MODE_TIMER   = 2'h3  // timer/counter
    } stc_mode_e;

    localparam logic [2:0] CLK_SYS_DIV4   = 3'h0; // system_clock / 4
    localparam logic [2:0] CLK_SYS        = 3'h1; // system_clock
    localparam logic [2:0] CLK_HIGH_DIV16 = 3'h2; // high_speed_clock / 16
    localparam logic [2:0] CLK_HIGH_DIV64 = 3'h3; // high_speed_clock / 64
    localparam logic [2:0] CLK_SUB_A      = 3'h4; // sub_clock
    localparam logic [2:0] CLK_SUB_B      = 3'h5; // sub_clock
    localparam logic [2:0] CLK_EXT_RISE   = 3'h6; // external pin rising edge
    localparam logic [2:0] CLK_EXT_FALL   = 3'h7; // external pin falling edge

    localparam logic [1:0] ACT_NONE   = 2'h0; // compare: no change / pwm: inactive
    localparam logic [1:0] ACT_LOW    = 2'h1; // compare: low / pwm: active
    localparam logic [1:0] ACT_HIGH   = 2'h2; // compare: high / pwm: waveform
    localparam logic [1:0] ACT_TOGGLE = 2'h3; // compare: toggle / single pulse

    localparam logic [5:0] PRE_DIV4  = 6'h03; // prescaler masks
    localparam logic [5:0] PRE_DIV16 = 6'h0f;
    localparam logic [5:0] PRE_DIV64 = 6'h3f;
    localparam logic [16:0] FULL_SPAN = 17'h10000; // 65536 clocks

    // ************************************************
    // register layouts
    // ************************************************
    typedef struct packed {
        logic       count_pause;         // bit 7
        logic [2:0] clock_source_select; // bits 6..4
        logic       timer_run;           // bit 3
    } stc_ctrl0_s;

    typedef struct packed {
        stc_mode_e  operating_mode_select; // bits 7..6
        logic [1:0] pin_action_select;     // bits 5..4
        logic       output_initial_level;  // bit 3
        logic       output_invert;         // bit 2
        logic       duty_period_swap;      // bit 1
        logic       clear_source_select;   // bit 0
    } stc_ctrl1_s;

    // whole block state, registered in one place
    typedef struct packed {
        stc_ctrl0_s        c0;       // first control
        stc_ctrl1_s        c1;       // second control
        logic [15:0]       cmpa;     // compare_a_value
        logic [7:0]        cmpp;     // compare_p_value
        logic [15:0]       cnt;      // live counter
        logic              run_prev; // run bit one cycle ago
        logic [5:0]        pre;      // free prescaler
        logic [SUB_W-1:0]  sub;      // sub clock divider
        logic [2:0]        ext_sync; // pin synchroniser and delay
        logic              level;    // output level before invert
        logic              pin;      // timer_output_pin
        logic              flag_a;   // compare_a_flag
        logic              flag_p;   // compare_p_flag
        logic              pready;   // apb answer
        logic              pslverr;  // apb error
        logic [31:0]       prdata;   // apb read data
    } stc_state_s;

    localparam stc_state_s STATE_RESET = '0; // everything powers up at zero

endpackage

/* File: src/stc_timer.sv */
`timescale 1ns/10ps
module stc_timer #(
    parameter int unsigned SUB_DIV = stc_pkg::SUB_DIV_DEF // sub clock divide
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // pins
    input  wire logic        external_count_input,
    output logic             timer_output_pin,
    // event flags
    output logic             compare_a_flag,
    output logic             compare_p_flag
);

    // ************************************************
    // elaboration check
    // ************************************************
    // the sub divider must fit its counter and tick at all
    if (SUB_DIV < 2 || SUB_DIV > (1 << stc_pkg::SUB_W)) begin : g_bad_div
        $error("SUB_DIV out of range");
    end

    localparam logic [stc_pkg::SUB_W-1:0] SUB_LAST =
        stc_pkg::SUB_W'(SUB_DIV - 1); // last divider count

    // ************************************************
    // state and working signals
    // ************************************************
    stc_pkg::stc_state_s s_reg;     // registered state
    stc_pkg::stc_state_s s_next;    // next state
    logic                acc;       // apb access phase
    logic                take;      // first access cycle, answer prepared
    logic                we;        // write takes effect now
    logic                mapped;    // address decodes
    logic [7:0]          rd;        // read byte
    logic [7:0]          wb;        // write byte
    logic                tick;      // selected clock active edge
    logic                sub_tick;  // sub clock enable
    logic                run;       // timer_run
    logic                rise;      // run low to high
    logic                count_en;  // counter advances now
    logic [16:0]         nv;        // counter plus one
    logic                a_hit;     // comparator A match
    logic                p_hit;     // comparator P match
    logic                clr;       // counter clears instead of steps
    logic                pwm_mode;  // pwm or single pulse mode
    logic                single;    // single pulse selected
    logic                ev_a;      // A flag event
    logic                ev_p;      // P flag event
    logic                active;    // pwm active level
    logic [16:0]         duty;      // pwm duty span
    logic                pwm_on;    // pwm in active part

    // ************************************************
    // next state
    // ************************************************
    // one process holds all behaviour; the flop stage below only registers it
    always_comb begin
        s_next   = s_reg;
        rd       = 8'h00;
        wb       = pwdata[7:0];
        mapped   = 1'b1;
        tick     = 1'b0;
        duty     = 17'h00000;
        acc      = psel & penable;
        take     = acc & ~s_reg.pready;
        we       = acc & s_reg.pready & pwrite & ~s_reg.pslverr & pstrb[0];
        run      = s_reg.c0.timer_run;
        rise     = run & ~s_reg.run_prev;
        pwm_mode = (s_reg.c1.operating_mode_select == stc_pkg::MODE_PWM);
        single   = pwm_mode & (s_reg.c1.pin_action_select == stc_pkg::ACT_TOGGLE);
        active   = s_reg.c1.output_initial_level;

        // dividers run freely so every rate is a one-cycle enable
        s_next.pre = s_reg.pre + 6'h01;
        sub_tick   = (s_reg.sub == SUB_LAST);
        s_next.sub = sub_tick ? '0 : s_reg.sub + 1'b1;

        // pin passes two flops before the edge detector reads it
        s_next.ext_sync = {s_reg.ext_sync[1:0], external_count_input};

        // counting clock selection
        case (s_reg.c0.clock_source_select)
            stc_pkg::CLK_SYS_DIV4: begin
                tick = (s_reg.pre[1:0] == stc_pkg::PRE_DIV4[1:0]);
            end
            stc_pkg::CLK_SYS: begin
                tick = 1'b1;
            end
            stc_pkg::CLK_HIGH_DIV16: begin
                tick = (s_reg.pre[3:0] == stc_pkg::PRE_DIV16[3:0]);
            end
            stc_pkg::CLK_HIGH_DIV64: begin
                tick = (s_reg.pre == stc_pkg::PRE_DIV64);
            end
            stc_pkg::CLK_SUB_A, stc_pkg::CLK_SUB_B: begin
                tick = sub_tick;
            end
            stc_pkg::CLK_EXT_RISE: begin
                tick = s_reg.ext_sync[1] & ~s_reg.ext_sync[2];
            end
            stc_pkg::CLK_EXT_FALL: begin
                tick = ~s_reg.ext_sync[1] & s_reg.ext_sync[2];
            end
            default: begin
                tick = 1'b0;
            end
        endcase

        // ************************************************
        // counter and comparators
        // ************************************************
        // the rise cycle only zeroes, so counting starts cleanly after it
        count_en = run & ~s_reg.c0.count_pause & tick & ~rise;
        nv       = {1'b0, s_reg.cnt} + 17'h00001;
        // compare A zero never matches, so overflow alone raises no A flag
        a_hit    = count_en & (s_reg.cmpa != 16'h0000)
                 & (nv[15:0] == s_reg.cmpa);
        // P compares the upper byte; zero means the 65536 overflow
        if (s_reg.cmpp == 8'h00) begin
            p_hit = count_en & nv[16];
        end else begin
            p_hit = count_en & (nv[15:8] == s_reg.cmpp) & (nv[7:0] == 8'h00);
        end

        // clear source and flag qualification per mode
        if (pwm_mode) begin
            // the period register clears, the clear source bit is not looked at
            clr  = s_reg.c1.duty_period_swap ? a_hit : p_hit;
            ev_p = p_hit;
        end else begin
            clr  = s_reg.c1.clear_source_select ? a_hit : p_hit;
            ev_p = p_hit & ~s_reg.c1.clear_source_select;
        end
        ev_a = a_hit;

        if (rise) begin
            s_next.cnt = 16'h0000;
        end else if (count_en) begin
            s_next.cnt = clr ? 16'h0000 : nv[15:0];
        end
        // paused or stopped: counter simply keeps its value
        s_next.run_prev = run;

        // ************************************************
        // output waveform
        // ************************************************
        // duty span for the pwm comparison, period follows from the clear
        if (s_reg.c1.duty_period_swap) begin
            duty = (s_reg.cmpp == 8'h00) ? stc_pkg::FULL_SPAN
                 : {1'b0, s_reg.cmpp, 8'h00};
        end else begin
            duty = {1'b0, s_reg.cmpa};
        end
        // duty at or past the period stays active all period
        pwm_on = ({1'b0, s_reg.cnt} < duty);

        case (s_reg.c1.operating_mode_select)
            stc_pkg::MODE_COMPARE: begin
                if (rise) begin
                    s_next.level = s_reg.c1.output_initial_level;
                end else if (a_hit) begin
                    // driving the level already shown leaves the pin still
                    case (s_reg.c1.pin_action_select)
                        stc_pkg::ACT_LOW:    s_next.level = 1'b0;
                        stc_pkg::ACT_HIGH:   s_next.level = 1'b1;
                        stc_pkg::ACT_TOGGLE: s_next.level = ~s_reg.level;
                        default:             s_next.level = s_reg.level;
                    endcase
                end
            end
            stc_pkg::MODE_PWM: begin
                case (s_reg.c1.pin_action_select)
                    stc_pkg::ACT_NONE:   s_next.level = ~active;
                    stc_pkg::ACT_LOW:    s_next.level = active;
                    stc_pkg::ACT_HIGH:   s_next.level = pwm_on ? active : ~active;
                    stc_pkg::ACT_TOGGLE: s_next.level = run ? active : ~active;
                    default:             s_next.level = s_reg.level;
                endcase
            end
            default: begin
                // timer mode and the undefined code leave the level alone
                s_next.level = s_reg.level;
            end
        endcase
        // invert only outside timer mode; the pin is undefined there anyway
        s_next.pin = s_next.level
                   ^ (s_reg.c1.output_invert
                      & (s_reg.c1.operating_mode_select != stc_pkg::MODE_TIMER));

        // a single pulse ends at compare A: hardware drops the run bit
        if (single & a_hit) begin
            s_next.c0.timer_run = 1'b0;
        end

        // ************************************************
        // apb read and write
        // ************************************************
        case (paddr)
            stc_pkg::ADDR_CTRL_FIRST:  rd = {s_reg.c0, 3'b000};
            stc_pkg::ADDR_CTRL_SECOND: rd = s_reg.c1;
            stc_pkg::ADDR_CNT_LOW:     rd = s_reg.cnt[7:0];
            stc_pkg::ADDR_CNT_HIGH:    rd = s_reg.cnt[15:8];
            stc_pkg::ADDR_CMPA_LOW:    rd = s_reg.cmpa[7:0];
            stc_pkg::ADDR_CMPA_HIGH:   rd = s_reg.cmpa[15:8];
            stc_pkg::ADDR_CMPP:        rd = s_reg.cmpp;
            stc_pkg::ADDR_FLAGS: begin
                rd[stc_pkg::FLAG_A_BIT] = s_reg.flag_a;
                rd[stc_pkg::FLAG_P_BIT] = s_reg.flag_p;
            end
            default: mapped = 1'b0;
        endcase

        // one wait state: answer registered in the first access cycle
        s_next.pready  = take;
        s_next.pslverr = take & ~mapped;
        if (take) begin
            s_next.prdata = {24'h000000, rd};
        end

        // writes land at the edge where pready is seen high
        if (we) begin
            case (paddr)
                stc_pkg::ADDR_CTRL_FIRST: begin
                    // software write to the run bit wins over the pulse end
                    s_next.c0 = wb[7:stc_pkg::CTRL0_LSB];
                end
                stc_pkg::ADDR_CTRL_SECOND: s_next.c1 = wb;
                stc_pkg::ADDR_CMPA_LOW:    s_next.cmpa[7:0] = wb;
                stc_pkg::ADDR_CMPA_HIGH:   s_next.cmpa[15:8] = wb;
                stc_pkg::ADDR_CMPP:        s_next.cmpp = wb;
                default: begin
                    // counter bytes are read only, flags handled below
                end
            endcase
        end

        // flags: a new event beats a clear in the same cycle
        s_next.flag_a = ev_a | (s_reg.flag_a
                      & ~(we & (paddr == stc_pkg::ADDR_FLAGS) & wb[stc_pkg::FLAG_A_BIT]));
        s_next.flag_p = ev_p | (s_reg.flag_p
                      & ~(we & (paddr == stc_pkg::ADDR_FLAGS) & wb[stc_pkg::FLAG_P_BIT]));
    end

    // ************************************************
    // state register
    // ************************************************
    // everything resets to zero, matching the power-on values
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_reg <= stc_pkg::STATE_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    // ************************************************
    // outputs straight from flops
    // ************************************************
    assign prdata           = s_reg.prdata;
    assign pready           = s_reg.pready;
    assign pslverr          = s_reg.pslverr;
    assign timer_output_pin = s_reg.pin;
    assign compare_a_flag   = s_reg.flag_a;
    assign compare_p_flag   = s_reg.flag_p;

endmodule

/* File: verification/stc_pin_model.sv */
`timescale 1ns/10ps
// ************************************************
// external count pin driver
// ************************************************
module stc_pin_model (
    // clock
    input  wire logic       clk,
    // command: send this many pulses when go is high
    input  wire logic       go,
    input  wire logic [7:0] edges,
    // pin
    output logic            ext
);
    logic [11:0] left = 12'h000; // clocks of pulse train still to send

    // sixteen clocks a pulse, half high, so the two-flop sync never misses one
    always_ff @(posedge clk) begin
        if (go) begin
            left <= {edges, 4'h0};
        end else if (left != 12'h000) begin
            left <= left - 12'h001;
        end
    end

    // idles low between trains, so no stray edge appears on a source change
    assign ext = left[3];
endmodule

/* File: verification/stc_timer_checker.sv */
`timescale 1ns/10ps
// ************************************************
// port-level checker
// ************************************************
module stc_timer_checker (
    // clock and reset
    input wire logic        clk,
    input wire logic        arst_n,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // flags
    input wire logic        compare_a_flag,
    input wire logic        compare_p_flag
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    logic clr_wr; // a flags write completes; may clear, so holds are not claimed
    assign clr_wr = pready && pwrite && paddr == 8'h1c && pstrb[0];

    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready stood longer than one cycle");
    a_ready_after: assert property (psel && penable && !pready |=> pready)
        else $error("ready missing after first access cycle");
    a_ready_cause: assert property (pready |-> $past(psel && penable))
        else $error("ready without access");
    a_err_decode: assert property (pready |-> pslverr == (paddr[1:0] != 2'h0 || paddr > 8'h1c))
        else $error("error flag disagrees with address map");
    a_err_read_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    a_rdata_upper: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    a_ctrl_low_zero: assert property (pready && !pwrite && paddr == 8'h00 |-> prdata[2:0] == 3'h0)
        else $error("control low bits not zero");
    a_flag_a_hold: assert property (compare_a_flag && !clr_wr |=> compare_a_flag)
        else $error("compare a flag dropped without clear");
    a_flag_p_hold: assert property (compare_p_flag && !clr_wr |=> compare_p_flag)
        else $error("compare p flag dropped without clear");

    c_write: cover property (pready && pwrite);
    c_unmapped: cover property (pslverr);
    c_flag_a: cover property ($rose(compare_a_flag));
    c_flag_p: cover property ($rose(compare_p_flag));
endmodule

bind stc_timer stc_timer_checker stc_timer_checker_i (
    .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .compare_a_flag(compare_a_flag), .compare_p_flag(compare_p_flag)
);

/* File: verification/stc_timer_bench.sv */
`timescale 1ns/10ps
module stc_timer_bench;
    // ************************************************
    // signals
    // ************************************************
    logic        clk = 1'b0, arst_n = 1'b0, go = 1'b0;   // clock, reset, pulse command
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // apb request
    logic [7:0]  paddr = 8'h00, edges = 8'h00;            // address, pulse count
    logic [31:0] pwdata = 32'h0, prdata, rv, rv2;         // apb data, scratch
    logic [3:0]  pstrb = 4'hf;                            // byte strobes
    logic        pready, pslverr, pin, fa, fp, ext, er;   // answers, pins, flags
    int          miscompares = 0, checks = 0, cyc = 0;    // tallies

    stc_timer #(.SUB_DIV(4)) stc_timer_i (
        .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .external_count_input(ext), .timer_output_pin(pin),
        .compare_a_flag(fa), .compare_p_flag(fp));
    stc_pin_model stc_pin_model_i (.clk(clk), .go(go), .edges(edges), .ext(ext));

    // clock and hang guard; the run needs under ten thousand cycles
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            miscompares++;
            wrap_up();
        end
    end

    // ************************************************
    // shared tasks
    // ************************************************
    task automatic wrap_up;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one apb transfer, then one idle edge so a following call never
    // reassigns psel in the same time step; entered and left after a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rv = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    // stop, set second control, clear flags, start with a clock source
    task automatic go_run(input logic [7:0] c1, input logic [2:0] sel);
        apb(1'b1, 8'h00, 8'h00);
        apb(1'b1, 8'h04, c1);
        apb(1'b1, 8'h1c, 8'h03);
        apb(1'b1, 8'h00, {1'b0, sel, 4'h8});
    endtask
    // count high samples of the pin over a window
    task automatic duty(input logic [7:0] c1, input int win, input int exp);
        int n;
        n = 0;
        go_run(c1, 3'h1);
        repeat (8) @(posedge clk);
        repeat (win) begin
            @(posedge clk);
            n += (pin === 1'b1);
        end
        check(n, exp);
    endtask

    // ************************************************
    // scenarios
    // ************************************************
    task automatic t_regs;
        logic [7:0] wa[7] = '{8'h04, 8'h10, 8'h14, 8'h18, 8'h08, 8'h00, 8'h20};
        logic [7:0] wd[7] = '{8'hda, 8'h5a, 8'ha5, 8'h3c, 8'hff, 8'h87, 8'h11};
        logic [7:0] we[7] = '{8'hda, 8'h5a, 8'ha5, 8'h3c, 8'h00, 8'h80, 8'h00};
        for (int i = 0; i < 8; i++) begin
            apb(1'b0, 8'(4 * i), 8'h00);
            check(rv, 32'h0);
        end
        for (int i = 0; i < 7; i++) begin
            apb(1'b1, wa[i], wd[i]);
            apb(1'b0, wa[i], 8'h00);
            check(rv, {24'h0, we[i]});
            check(er, i == 6);
        end
    endtask
    task automatic t_rates;
        int dv[6] = '{4, 1, 16, 64, 4, 4};
        for (int i = 0; i < 6; i++) begin
            go_run(8'h00, 3'(i));
            apb(1'b0, 8'h08, 8'h00);
            rv2 = rv;
            repeat (2 * dv[i]) apb(1'b0, 8'h08, 8'h00);
            // 2*dv reads of four clocks each span 8*dv clocks, so eight ticks
            check(8'(rv - rv2), 32'd8);
        end
        for (int i = 6; i < 8; i++) begin
            go_run(8'h00, 3'(i));
            apb(1'b0, 8'h08, 8'h00);
            rv2 = rv;
            edges <= 8'd5;
            go <= 1'b1;
            @(posedge clk);
            go <= 1'b0;
            repeat (100) @(posedge clk);
            apb(1'b0, 8'h08, 8'h00);
            check(8'(rv - rv2), 32'd5);
        end
    endtask
    task automatic t_pause;
        go_run(8'h00, 3'h1);
        repeat (300) @(posedge clk);
        apb(1'b1, 8'h00, 8'h98);
        apb(1'b0, 8'h08, 8'h00);
        rv2 = rv;
        repeat (20) @(posedge clk);
        apb(1'b0, 8'h08, 8'h00);
        check(rv, rv2);
        apb(1'b1, 8'h00, 8'h18);
        apb(1'b0, 8'h0c, 8'h00);
        check(rv, 32'h1);
        apb(1'b1, 8'h00, 8'h10);
        apb(1'b0, 8'h08, 8'h00);
        rv2 = rv;
        repeat (20) @(posedge clk);
        apb(1'b0, 8'h08, 8'h00);
        check(rv, rv2);
        apb(1'b1, 8'h00, 8'h18);
        apb(1'b0, 8'h0c, 8'h00);
        check(rv, 32'h0);
    endtask
    task automatic t_compare;
        logic e;
        apb(1'b1, 8'h10, 8'd20);
        apb(1'b1, 8'h14, 8'h00);
        apb(1'b1, 8'h18, 8'h00);
        for (int i = 0; i < 16; i++) begin
            go_run({2'b00, 4'(i), 2'b00}, 3'h1);
            repeat (4) @(posedge clk);
            check(pin, i[1] ^ i[0]);
            check(fa, 1'b0);
            repeat (30) @(posedge clk);
            e = (i[3:2] == 2'h0) ? i[1] : (i[3:2] == 2'h3) ? !i[1] : i[3];
            check(pin, e ^ i[0]);
            check(fa, 1'b1);
        end
        apb(1'b1, 8'h00, 8'h00);
        apb(1'b1, 8'h04, 8'hc0);
        // the pin lags the control write by one clock, so let it settle first
        @(posedge clk);
        rv2 = {31'h0, pin};
        apb(1'b1, 8'h04, 8'hc4);
        repeat (3) @(posedge clk);
        check(pin, rv2);
    endtask
    task automatic t_clear;
        apb(1'b1, 8'h10, 8'd50);
        go_run(8'h01, 3'h1);
        repeat (200) @(posedge clk);
        check(fa, 1'b1);
        check(fp, 1'b0);
        apb(1'b0, 8'h08, 8'h00);
        check(rv < 32'd50, 1'b1);
        apb(1'b1, 8'h10, 8'h00);
        apb(1'b1, 8'h18, 8'h01);
        go_run(8'h00, 3'h1);
        repeat (600) @(posedge clk);
        check(fp, 1'b1);
        check(fa, 1'b0);
        apb(1'b0, 8'h0c, 8'h00);
        check(rv, 32'h0);
    endtask
    task automatic t_pwm;
        apb(1'b1, 8'h10, 8'd64);
        duty(8'ha9, 512, 128);
        duty(8'ha1, 512, 384);
        duty(8'h88, 64, 0);
        duty(8'h98, 64, 64);
        apb(1'b1, 8'h10, 8'h00);
        apb(1'b1, 8'h14, 8'h04);
        duty(8'haa, 2048, 512);
        apb(1'b1, 8'h10, 8'd100);
        apb(1'b1, 8'h14, 8'h00);
        go_run(8'hb8, 3'h1);
        repeat (10) @(posedge clk);
        check(pin, 1'b1);
        repeat (150) @(posedge clk);
        check(pin, 1'b0);
        apb(1'b0, 8'h00, 8'h00);
        check(rv, 32'h10);
    endtask

    // ************************************************
    // main sequence
    // ************************************************
    initial begin
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        t_regs();
        t_rates();
        t_pause();
        t_compare();
        t_clear();
        t_pwm();
        wrap_up();
    end
endmodule
